//--- design/ccpu_unit.sv
// Four-channel capture/compare/PWM unit with its byte register port.
// Assumes free-running timers and pins synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module ccpu_unit (
  input  wire logic                                 clk_sys,
  input  wire logic                                 rst_n,
  input  wire logic [ccpu_pkg::CCPU_AW-1:0]         reg_addr,
  input  wire logic [7:0]                           reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  output logic      [7:0]                           reg_rdata,
  input  wire logic [ccpu_pkg::CCPU_TW-1:0]         timer_one_cnt,
  input  wire logic [ccpu_pkg::CCPU_TW-1:0]         timer_three_cnt,
  output logic                                      timer_one_reset,
  output logic                                      timer_three_reset,
  input  wire logic [ccpu_pkg::CCPU_NCH-1:0]        chan_pin_in,
  input  wire logic [ccpu_pkg::CCPU_NCH-1:0]        port_latch,
  output logic      [ccpu_pkg::CCPU_NCH-1:0]        chan_pin_out,
  output logic      [ccpu_pkg::CCPU_NCH-1:0]        chan_pin_oe,
  input  wire logic                                 can_msg_rx,
  output logic      [ccpu_pkg::CCPU_NCH-1:0]        channel_interrupt_flag,
  output logic      [ccpu_pkg::CCPU_NCH-1:0]        pwm_active,
  output logic      [10*ccpu_pkg::CCPU_NCH-1:0]     pwm_duty
);
  import ccpu_pkg::*;

  // Register storage.
  logic [5:0]         ctl_r [CCPU_NCH];  // Duty low bits and mode field.
  logic [CCPU_TW-1:0] data_r [CCPU_NCH]; // Data register, no reset.
  logic [4:0]         tsel_r;            // Timer-select bits.
  logic               can_ts_r;          // CAN time-stamp select.
  logic [CCPU_NCH-1:0] flag_r;           // Sticky channel flags.
  logic [7:0]         rdata_r;           // Registered read data.
  logic               t1_rst_r;          // Timer one reset pulse.
  logic               t3_rst_r;          // Timer three reset pulse.
  logic [CCPU_NCH-1:0] match_prev_r;     // Match seen last cycle.
  logic [9:0]         duty_r [CCPU_NCH]; // Duty handed to PWM logic.
  logic [CCPU_NCH-1:0] pwm_r;            // PWM active per channel.

  // Per-channel combinational terms and the read mux.
  logic [CCPU_TW-1:0] timer_val [CCPU_NCH]; // Selected timer count.
  logic [CCPU_NCH-1:0] capture;             // Capture this cycle.
  logic [CCPU_NCH-1:0] match_raw;           // Data equals timer.
  logic [CCPU_NCH-1:0] match_hit;           // Rising edge of match.
  logic [CCPU_NCH-1:0] trig;                // Timer reset request.
  logic [CCPU_NCH-1:0] ctl_we;              // Control byte write.
  logic [CCPU_NCH-1:0] dlo_we;              // Data low byte write.
  logic [CCPU_NCH-1:0] dhi_we;              // Data high byte write.
  logic [CCPU_NCH-1:0] flag_clr;            // Software flag clear.
  logic [7:0]          rd_mux;              // Read data before register.

  // Decode a per-channel byte write in the given group.
  function automatic logic [CCPU_NCH-1:0] grp_we(input logic [1:0] g);
    logic [CCPU_NCH-1:0] v;
    v = '0;
    if (reg_wr && reg_addr[3:2] == g) begin
      v[reg_addr[1:0]] = 1'b1;
    end
    return v;
  endfunction : grp_we

  // Write strobes for the channel bytes and the flag clear.
  always_comb begin
    ctl_we   = grp_we(CCPU_G_CTL);
    dlo_we   = grp_we(CCPU_G_DLO);
    dhi_we   = grp_we(CCPU_G_DHI);
    flag_clr = (reg_wr && reg_addr == CCPU_A_FLAG) ?
               reg_wdata[CCPU_NCH-1:0] : '0;
  end

  // Build the four channels from one template.
  for (genvar i = 0; i < CCPU_NCH; i++) begin : g_chan
    ccpu_chan_if u_if ();

    // Timer pair chosen by this channel's select bit.
    assign timer_val[i] = tsel_r[i+1] ? timer_three_cnt
                                      : timer_one_cnt;

    // Compare only in compare modes, acting on the match edge.
    assign match_raw[i] = ccpu_is_cmp(ctl_r[i][3:0]) &&
                          (data_r[i] == timer_val[i]);
    assign match_hit[i] = match_raw[i] & ~match_prev_r[i];
    assign trig[i]      = match_hit[i] &&
                          (ctl_r[i][3:0] == CCPU_CMP_TRIG);

    // Feed the helper modules.
    assign u_if.mode         = ctl_r[i][3:0];
    assign u_if.new_mode     = reg_wdata[3:0];
    assign u_if.mode_entered = ctl_we[i];
    assign u_if.pin_in       = chan_pin_in[i];
    assign u_if.can_sel      = (i == 0) ? can_ts_r : 1'b0;
    assign u_if.can_event    = can_msg_rx;
    assign u_if.match_hit    = match_hit[i];
    assign u_if.port_latch   = port_latch[i];
    assign capture[i]        = u_if.capture;
    assign chan_pin_out[i]   = u_if.pin_out;
    assign chan_pin_oe[i]    = u_if.pin_oe;

    ccpu_cap_evt u_evt (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .ch      (u_if)
    );

    ccpu_cmp_pin u_cmp (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .ch      (u_if)
    );

    // Data halves: a capture wins over a software byte write.
    always_ff @(posedge clk_sys) begin
      if (capture[i]) begin
        data_r[i] <= timer_val[i];
      end else begin
        if (dlo_we[i]) begin
          data_r[i][7:0] <= reg_wdata;
        end
        if (dhi_we[i]) begin
          data_r[i][15:8] <= reg_wdata;
        end
      end
    end

    // Control byte; only the low six bits exist.
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        ctl_r[i] <= CCPU_CTL_RST;
      end else if (ctl_we[i]) begin
        ctl_r[i] <= reg_wdata[5:0];
      end
    end

    // Duty goes out only in PWM; otherwise the low bits are ignored.
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        duty_r[i] <= 10'h000;
        pwm_r[i]  <= 1'b0;
      end else if (ccpu_is_pwm(ctl_r[i][3:0])) begin
        duty_r[i] <= {data_r[i][7:0],
                      ctl_r[i][CCPU_DUTY_LSB +: 2]};
        pwm_r[i]  <= 1'b1;
      end else begin
        duty_r[i] <= 10'h000;
        pwm_r[i]  <= 1'b0;
      end
    end

    assign pwm_duty[10*i +: 10] = duty_r[i];

    // A capture stores the timer and raises the flag.
    a_cap_loads:
      assert property (@(posedge clk_sys) disable iff (!rst_n)
        capture[i] |=> data_r[i] == $past(timer_val[i]) && flag_r[i])
      else $error("Capture did not store timer and flag.");

    // PWM duty is data low byte above control bits 5-4.
    a_pwm_duty:
      assert property (@(posedge clk_sys) disable iff (!rst_n)
        ccpu_is_pwm(ctl_r[i][3:0]) |=>
        duty_r[i] == {$past(data_r[i][7:0]), $past(ctl_r[i][5:4])})
      else $error("PWM duty not formed from data and control.");

    // Disabled or reserved modes never raise a flag.
    a_off_quiet:
      assert property (@(posedge clk_sys) disable iff (!rst_n)
        !flag_r[i] && !ccpu_is_cap(ctl_r[i][3:0])
        && !ccpu_is_cmp(ctl_r[i][3:0]) |=> !flag_r[i])
      else $error("Flag set while channel disabled.");

    // Outside PWM the duty output stays zero.
    a_duty_off:
      assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ccpu_is_pwm(ctl_r[i][3:0]) |=> duty_r[i] == 10'h000 && !pwm_r[i])
      else $error("Duty driven outside PWM.");

    // A trigger match on timer one pulses its reset for one cycle.
    a_trig_reset:
      assert property (@(posedge clk_sys) disable iff (!rst_n)
        trig[i] && !tsel_r[i+1] |=> timer_one_reset ##1
        (!timer_one_reset || $past(|trig)))
      else $error("Trigger match did not pulse timer one reset.");

    // A trigger match on timer three pulses its reset.
    a_trig_three:
      assert property (@(posedge clk_sys) disable iff (!rst_n)
        trig[i] && tsel_r[i+1] |=> timer_three_reset)
      else $error("Trigger match did not pulse timer three reset.");

    // A compare match raises the flag.
    a_match_flag:
      assert property (@(posedge clk_sys) disable iff (!rst_n)
        match_hit[i] |=> flag_r[i])
      else $error("Compare match did not raise the flag.");

    // A low byte write lands unless a capture takes the cycle.
    a_wr_low:
      assert property (@(posedge clk_sys) disable iff (!rst_n)
        dlo_we[i] && !capture[i] |=> data_r[i][7:0] == $past(reg_wdata))
      else $error("Data low byte write lost.");

    // A flag stays set until software clears it.
    a_flag_hold:
      assert property (@(posedge clk_sys) disable iff (!rst_n)
        flag_r[i] && !flag_clr[i] |=> flag_r[i])
      else $error("Flag dropped without a clear.");
  end

  assign pwm_active = pwm_r;

  // Timer select register; bits above four do not exist.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tsel_r <= CCPU_TSEL_RST;
    end else if (reg_wr && reg_addr == CCPU_A_TSEL) begin
      tsel_r <= reg_wdata[4:0];
    end
  end

  // CAN time-stamp select bit.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      can_ts_r <= 1'b0;
    end else if (reg_wr && reg_addr == CCPU_A_CANC) begin
      can_ts_r <= reg_wdata[0];
    end
  end

  // Sticky flags: a new event wins over a clear in the same cycle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= '0;
    end else begin
      flag_r <= (flag_r & ~flag_clr) | capture | match_hit;
    end
  end

  // Match history so a held equality acts only once.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      match_prev_r <= '0;
    end else begin
      match_prev_r <= match_raw;
    end
  end

  // One-cycle timer reset pulses on a trigger-mode match.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      t1_rst_r <= 1'b0;
      t3_rst_r <= 1'b0;
    end else begin
      t1_rst_r <= |(trig & ~tsel_r[4:1]);
      t3_rst_r <= |(trig & tsel_r[4:1]);
    end
  end

  assign timer_one_reset   = t1_rst_r;
  assign timer_three_reset = t3_rst_r;
  assign channel_interrupt_flag = flag_r;

  // Select the byte being read; unmapped addresses read zero.
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr[3:2])
      CCPU_G_CTL: rd_mux = {2'b00, ctl_r[reg_addr[1:0]]};
      CCPU_G_DLO: rd_mux = data_r[reg_addr[1:0]][7:0];
      CCPU_G_DHI: rd_mux = data_r[reg_addr[1:0]][15:8];
      default: begin
        if (reg_addr == CCPU_A_TSEL) begin
          rd_mux = {3'b000, tsel_r};
        end else if (reg_addr == CCPU_A_CANC) begin
          rd_mux = {7'h00, can_ts_r};
        end else if (reg_addr == CCPU_A_FLAG) begin
          rd_mux = {4'h0, flag_r};
        end else begin
          rd_mux = 8'h00;
        end
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_r;

  // Control reads show zero in the two unused top bits.
  a_ctl_rsvd:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      reg_rd && reg_addr[3:2] == CCPU_G_CTL |=> reg_rdata[7:6] == 2'b00)
    else $error("Control read shows unused bits set.");

  // Without a read strobe the read data return to zero.
  a_rd_idle:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      !reg_rd |=> reg_rdata == 8'h00)
    else $error("Read data stood without a read.");

  // Select bits above four always read as zero.
  a_tsel_rsvd:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      reg_rd && reg_addr == CCPU_A_TSEL |=> reg_rdata[7:5] == 3'b000
      && reg_rdata[4:0] == $past(tsel_r))
    else $error("Timer select read back wrong.");

  // A control write shows in the mode field one cycle later.
  a_mode_next:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      ctl_we[1] |=> ctl_r[1] == $past(reg_wdata[5:0]))
    else $error("Control write not taken next cycle.");

endmodule : ccpu_unit
`default_nettype wire

//--- shared/ccpu_pkg.sv
// Constants, mode codes and decode helpers of the capture/compare unit.
// Assumes one byte-wide register port and four channels.
package ccpu_pkg;

  localparam int         CCPU_NCH     = 4;     // Number of channels.
  localparam int         CCPU_AW      = 4;     // Register address width.
  localparam int         CCPU_TW      = 16;    // Timer and data width.
  localparam int         CCPU_PSW     = 4;     // Prescale counter width.
  localparam logic [1:0] CCPU_G_CTL   = 2'h0;  // Control group, addr 0-3.
  localparam logic [1:0] CCPU_G_DLO   = 2'h1;  // Data low group, addr 4-7.
  localparam logic [1:0] CCPU_G_DHI   = 2'h2;  // Data high group, addr 8-B.
  localparam logic [3:0] CCPU_A_TSEL  = 4'hC;  // Timer-select register.
  localparam logic [3:0] CCPU_A_CANC  = 4'hD;  // CAN time-stamp select.
  localparam logic [3:0] CCPU_A_FLAG  = 4'hE;  // Interrupt flags, W1C.
  localparam logic [5:0] CCPU_CTL_RST = 6'h00; // Control reset value.
  localparam logic [4:0] CCPU_TSEL_RST = 5'h00; // Timer-select reset.
  localparam int         CCPU_DUTY_LSB = 4;    // Duty low bits position.
  localparam logic [3:0] CCPU_PS4_LAST  = 4'h3; // Last count, every 4th.
  localparam logic [3:0] CCPU_PS16_LAST = 4'hF; // Last count, every 16th.

  // Mode field codes.
  typedef enum logic [3:0] {
    CCPU_OFF        = 4'h0, CCPU_CMP_TOGGLE = 4'h2,
    CCPU_CAP_FALL   = 4'h4, CCPU_CAP_RISE   = 4'h5,
    CCPU_CAP_4TH    = 4'h6, CCPU_CAP_16TH   = 4'h7,
    CCPU_CMP_HIGH   = 4'h8, CCPU_CMP_LOW    = 4'h9,
    CCPU_CMP_SOFT   = 4'hA, CCPU_CMP_TRIG   = 4'hB
  } ccpu_mode_type;

  // True for the four capture modes.
  function automatic logic ccpu_is_cap(input logic [3:0] m);
    return m[3:2] == 2'h1;
  endfunction : ccpu_is_cap

  // True for the five compare modes.
  function automatic logic ccpu_is_cmp(input logic [3:0] m);
    return (m == CCPU_CMP_TOGGLE) || (m[3:2] == 2'h2);
  endfunction : ccpu_is_cmp

  // True for any PWM mode.
  function automatic logic ccpu_is_pwm(input logic [3:0] m);
    return m[3:2] == 2'h3;
  endfunction : ccpu_is_pwm

endpackage : ccpu_pkg

//--- shared/ccpu_chan_if.sv
// Per-channel bundle between the unit top and its two helper modules.
// Assumes the top drives mode and event inputs on the system clock.
`timescale 1ns/1ps
`default_nettype none
interface ccpu_chan_if;
  logic [3:0] mode;         // Current mode field.
  logic [3:0] new_mode;     // Mode being written this cycle.
  logic       mode_entered; // Control register written this cycle.
  logic       pin_in;       // Sampled input pin.
  logic       can_sel;      // Received message replaces the pin.
  logic       can_event;    // One-cycle message received pulse.
  logic       capture;      // Capture event this cycle.
  logic       match_hit;    // Rising compare match this cycle.
  logic       port_latch;   // Ordinary port latch level.
  logic       pin_out;      // Output pin level.
  logic       pin_oe;       // Output pin enable.
  modport evt (input mode, pin_in, can_sel, can_event, output capture);
  modport cmp (input mode, new_mode, mode_entered, match_hit, port_latch,
               output pin_out, pin_oe);
endinterface : ccpu_chan_if
`default_nettype wire

//--- design/ccpu_cap_evt.sv
// Capture event detector with edge select and prescaler for one channel.
// Assumes the pin is synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module ccpu_cap_evt (
  input wire logic  clk_sys,
  input wire logic  rst_n,
  ccpu_chan_if.evt  ch
);
  import ccpu_pkg::*;

  logic                pin_prev_r; // Pin level one cycle ago.
  logic [CCPU_PSW-1:0] ps_r;       // Prescale counter.
  logic                src;        // Qualifying edge or message.
  logic                qual;       // Source event in a capture mode.

  // Pick the event source; a message overrides the pin when selected.
  always_comb begin
    if (ch.can_sel) begin
      src = ch.can_event;
    end else if (ch.mode == CCPU_CAP_FALL) begin
      src = pin_prev_r & ~ch.pin_in;
    end else begin
      src = ~pin_prev_r & ch.pin_in;
    end
    qual = ccpu_is_cap(ch.mode) & src;
  end

  // Remember the pin for edge detection.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_r <= 1'b0;
    end else begin
      pin_prev_r <= ch.pin_in;
    end
  end

  // Count qualifying events; cleared outside capture modes.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ps_r <= '0;
    end else if (!ccpu_is_cap(ch.mode)) begin
      ps_r <= '0;
    end else if (qual) begin
      ps_r <= ps_r + 1'b1;
    end
  end

  // Fire on every event, every 4th or every 16th.
  assign ch.capture = qual &
    ((ch.mode == CCPU_CAP_4TH)  ? (ps_r[1:0] == CCPU_PS4_LAST[1:0]) :
     (ch.mode == CCPU_CAP_16TH) ? (ps_r == CCPU_PS16_LAST) : 1'b1);

  // Nothing is captured outside a capture mode.
  a_no_cap_off:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      !ccpu_is_cap(ch.mode) |-> !ch.capture)
    else $error("Capture fired outside a capture mode.");

  // The prescaler is empty one cycle after leaving capture.
  a_ps_cleared:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      !ccpu_is_cap(ch.mode) |=> ps_r == '0)
    else $error("Prescaler not cleared outside capture.");

endmodule : ccpu_cap_evt
`default_nettype wire

//--- design/ccpu_cmp_pin.sv
// Compare output pin latch of one channel.
// Assumes match_hit is a one-cycle pulse on a rising compare match.
`timescale 1ns/1ps
`default_nettype none
module ccpu_cmp_pin (
  input wire logic  clk_sys,
  input wire logic  rst_n,
  ccpu_chan_if.cmp  ch
);
  import ccpu_pkg::*;

  logic pin_r; // Output latch.
  logic oe_r;  // Output enable.

  // Initialise on a mode write, otherwise act on matches.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_r <= 1'b0;
      oe_r  <= 1'b0;
    end else if (ch.mode_entered) begin
      oe_r <= ccpu_is_cmp(ch.new_mode) | ccpu_is_pwm(ch.new_mode);
      case (ch.new_mode)
        CCPU_CMP_HIGH: pin_r <= 1'b0;
        CCPU_CMP_LOW:  pin_r <= 1'b1;
        CCPU_OFF:      pin_r <= 1'b0;
        default:       pin_r <= pin_r;
      endcase
    end else begin
      case (ch.mode)
        CCPU_OFF:        pin_r <= 1'b0;
        CCPU_CMP_TOGGLE: pin_r <= pin_r ^ ch.match_hit;
        CCPU_CMP_HIGH:   pin_r <= pin_r | ch.match_hit;
        CCPU_CMP_LOW:    pin_r <= pin_r & ~ch.match_hit;
        CCPU_CMP_SOFT:   pin_r <= ch.port_latch;
        default:         pin_r <= pin_r;
      endcase
    end
  end

  assign ch.pin_out = pin_r;
  assign ch.pin_oe  = oe_r;

  // A match in toggle mode inverts the pin.
  a_toggle_match:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      ch.mode == CCPU_CMP_TOGGLE && ch.match_hit && !ch.mode_entered
      |=> pin_r != $past(pin_r))
    else $error("Toggle mode did not invert the pin.");

  // Entering the force-high mode starts the pin low.
  a_force_high:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      ch.mode_entered && ch.new_mode == CCPU_CMP_HIGH |=> !pin_r)
    else $error("Force-high mode did not start low.");

  // A match in force-high mode raises the pin.
  a_high_match:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      ch.mode == CCPU_CMP_HIGH && ch.match_hit && !ch.mode_entered
      |=> pin_r)
    else $error("Force-high match did not raise the pin.");

endmodule : ccpu_cmp_pin
`default_nettype wire

//--- tb/ccpu_far_model.sv
// Far-side model: the two free-running timer pairs seen by the unit.
// Assumes the unit pulses a timer reset for one clk_sys cycle.
`timescale 1ns/1ps
`default_nettype none
module ccpu_far_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        timer_one_clr,
  input  wire logic        timer_three_clr,
  output logic      [15:0] timer_one,
  output logic      [15:0] timer_three
);
  // Timer one counts up; a reset pulse from the unit restarts it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_one <= 16'h0000;
    end else if (timer_one_clr) begin
      timer_one <= 16'h0000;
    end else begin
      timer_one <= timer_one + 16'h0001;
    end
  end
  // Timer three counts down, so a wrong timer pick shows at once.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_three <= 16'hFFFF;
    end else if (timer_three_clr) begin
      timer_three <= 16'h0000;
    end else begin
      timer_three <= timer_three - 16'h0001;
    end
  end
endmodule : ccpu_far_model
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench of the four-channel capture/compare unit.
// Assumes the byte register port and the timer model beside it.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ccpu_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  a = 4'h0;
  logic [7:0]  wd = 8'h00;
  logic        we = 1'b0;
  logic        re = 1'b0;
  logic [7:0]  rdat;
  logic [15:0] t1;
  logic [15:0] t3;
  logic        t1_rst;
  logic        t3_rst;
  logic [3:0]  pin = 4'h0;
  logic [3:0]  latch = 4'h5;
  logic [3:0]  pout;
  logic [3:0]  poe;
  logic        can = 1'b0;
  logic [3:0]  flag;
  logic [3:0]  pact;
  logic [39:0] duty;
  logic [15:0] v;
  logic [15:0] x;
  logic [15:0] y;
  int          bad_count = 0;
  int          n_compared = 0;
  // The clock toggles every 2 ns.
  always #2 clk_sys = ~clk_sys;
  ccpu_unit dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(a),
    .reg_wdata(wd), .reg_wr(we), .reg_rd(re), .reg_rdata(rdat),
    .timer_one_cnt(t1), .timer_three_cnt(t3), .timer_one_reset(t1_rst),
    .timer_three_reset(t3_rst), .chan_pin_in(pin), .port_latch(latch),
    .chan_pin_out(pout), .chan_pin_oe(poe), .can_msg_rx(can),
    .channel_interrupt_flag(flag), .pwm_active(pact), .pwm_duty(duty));
  ccpu_far_model far (.clk_sys(clk_sys), .rst_n(rst_n),
    .timer_one_clr(t1_rst), .timer_three_clr(t3_rst), .timer_one(t1),
    .timer_three(t3));
  // Compares one value and counts it.
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t saw %h want %h", $time, s, e);
    end
  endtask : chk
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("Compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  // One-cycle register write.
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk_sys);
    we <= 1'b1;
    a <= ad;
    wd <= d;
    @(posedge clk_sys);
    we <= 1'b0;
  endtask : wr
  // One-cycle read; data are taken in the following cycle.
  task automatic rd(input logic [3:0] ad, output logic [7:0] d);
    @(posedge clk_sys);
    re <= 1'b1;
    a <= ad;
    @(posedge clk_sys);
    re <= 1'b0;
    @(negedge clk_sys);
    d = rdat;
  endtask : rd
  // Reads both data bytes of one channel.
  task automatic rd16(input int ch, output logic [15:0] d);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(4'(4 + ch), lo);
    rd(4'(8 + ch), hi);
    d = {hi, lo};
  endtask : rd16
  // One pin pulse; returns the timer seen in the rise and fall cycles.
  task automatic pulse(input int ch, input logic sel,
                       output logic [15:0] tr, output logic [15:0] tf);
    @(posedge clk_sys);
    pin[ch] <= 1'b1;
    @(negedge clk_sys);
    tr = sel ? t3 : t1;
    @(posedge clk_sys);
    pin[ch] <= 1'b0;
    @(negedge clk_sys);
    tf = sel ? t3 : t1;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : pulse
  // One received-message pulse; returns timer one of that cycle.
  task automatic canp(output logic [15:0] t);
    @(posedge clk_sys);
    can <= 1'b1;
    @(negedge clk_sys);
    t = t1;
    @(posedge clk_sys);
    can <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : canp
  // Reset values, spare bits, byte halves and the unmapped address.
  task automatic t_regs;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      rd(4'(i), d);
      chk(16'(d), 16'h0000);
    end
    rd(CCPU_A_TSEL, d);
    chk(16'(d), 16'h0000);
    wr(CCPU_A_TSEL, 8'hFF);
    rd(CCPU_A_TSEL, d);
    chk(16'(d), 16'h001F);
    wr(4'h1, 8'hF7);
    rd(4'h1, d);
    chk(16'(d), 16'h0037);
    wr(4'h7, 8'h5A);
    wr(4'hB, 8'hC3);
    rd16(3, v);
    chk(v, 16'hC35A);
    rd(4'hF, d);
    chk(16'(d), 16'h0000);
    wr(CCPU_A_TSEL, 8'h00);
    wr(4'h1, 8'h00);
  endtask : t_regs
  // PWM duty is built from the low data byte and bits 5-4.
  task automatic t_pwm;
    wr(4'h4, 8'hA5);
    wr(4'h0, 8'h2C);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(16'(pact[0]), 16'h0001);
    chk(16'(duty[9:0]), 16'h0296);
    wr(4'h0, 8'h00);
  endtask : t_pwm
  // Edge captures, overwrite and a reserved mode.
  task automatic t_cap;
    wr(4'h0, 8'h05);
    wr(CCPU_A_FLAG, 8'h0F);
    pulse(0, 1'b0, x, y);
    rd16(0, v);
    chk(v, x);
    chk(16'(flag[0]), 16'h0001);
    pulse(0, 1'b0, x, y);
    rd16(0, v);
    chk(v, x);
    wr(4'h3, 8'h04);
    pulse(3, 1'b0, x, y);
    rd16(3, v);
    chk(v, y);
    wr(4'h2, 8'h01);
    wr(CCPU_A_FLAG, 8'h0F);
    pulse(2, 1'b0, x, y);
    chk(16'(flag[2]), 16'h0000);
  endtask : t_cap
  // Prescaled captures; turning off in mid-count clears the count.
  task automatic t_pre;
    wr(CCPU_A_TSEL, 8'h04);
    wr(4'h1, 8'h06);
    repeat (2) pulse(1, 1'b1, x, y);
    wr(4'h1, 8'h00);
    wr(4'h1, 8'h06);
    wr(CCPU_A_FLAG, 8'h0F);
    repeat (3) pulse(1, 1'b1, x, y);
    chk(16'(flag[1]), 16'h0000);
    pulse(1, 1'b1, x, y);
    chk(16'(flag[1]), 16'h0001);
    rd16(1, v);
    chk(v, x);
    wr(CCPU_A_TSEL, 8'h00);
    wr(4'h2, 8'h07);
    wr(CCPU_A_FLAG, 8'h0F);
    repeat (15) pulse(2, 1'b0, x, y);
    chk(16'(flag[2]), 16'h0000);
    pulse(2, 1'b0, x, y);
    chk(16'(flag[2]), 16'h0001);
  endtask : t_pre
  // Messages replace the pin of the first unit channel.
  task automatic t_can;
    wr(CCPU_A_CANC, 8'h01);
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h06);
    wr(CCPU_A_FLAG, 8'h0F);
    repeat (3) canp(x);
    pulse(0, 1'b0, y, y);
    chk(16'(flag[0]), 16'h0000);
    canp(x);
    chk(16'(flag[0]), 16'h0001);
    rd16(0, v);
    chk(v, x);
  endtask : t_can
  // Arms a compare 40 counts ahead and waits for the match.
  task automatic cmp(input int ch, input logic [3:0] m, input logic sel,
                     output logic b, output logic af, output logic rs);
    logic [15:0] t;
    wr(4'(ch), 8'h00);
    @(negedge clk_sys);
    t = sel ? t3 - 16'h0028 : t1 + 16'h0028;
    wr(4'(4 + ch), t[7:0]);
    wr(4'(8 + ch), t[15:8]);
    wr(CCPU_A_FLAG, 8'h0F);
    wr(4'(ch), {4'h3, m});
    @(negedge clk_sys);
    b = pout[ch];
    chk(16'(poe[ch]), 16'h0001);
    rs = 1'b0;
    for (int i = 0; i < 60 && flag[ch] !== 1'b1; i++) begin
      @(negedge clk_sys);
      rs = rs | (sel ? t3_rst : t1_rst);
    end
    af = pout[ch];
    chk(16'(flag[ch]), 16'h0001);
    chk(16'(duty[10*ch +: 10]), 16'h0000);
  endtask : cmp
  // Every compare mode, then disabling drops the pin.
  task automatic t_cmp;
    logic b;
    logic af;
    logic rs;
    cmp(1, CCPU_CMP_TOGGLE, 1'b0, b, af, rs);
    chk(16'({b, af}), 16'h0001);
    cmp(2, CCPU_CMP_HIGH, 1'b0, b, af, rs);
    chk(16'({b, af}), 16'h0001);
    cmp(3, CCPU_CMP_LOW, 1'b0, b, af, rs);
    chk(16'({b, af}), 16'h0002);
    cmp(0, CCPU_CMP_SOFT, 1'b0, b, af, rs);
    chk(16'(af), 16'h0001);
    @(posedge clk_sys);
    latch <= 4'h4;
    repeat (2) @(negedge clk_sys);
    chk(16'(pout[0]), 16'h0000);
    cmp(1, CCPU_CMP_TRIG, 1'b0, b, af, rs);
    chk(16'(rs), 16'h0001);
    wr(CCPU_A_TSEL, 8'h04);
    cmp(1, CCPU_CMP_TRIG, 1'b1, b, af, rs);
    chk(16'(rs), 16'h0001);
    wr(CCPU_A_TSEL, 8'h00);
    wr(4'h2, 8'h00);
    @(negedge clk_sys);
    chk(16'({pout[2], poe[2]}), 16'h0000);
  endtask : t_cmp
  // Main sequence.
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_pwm();
    t_cap();
    t_pre();
    t_can();
    t_cmp();
    tally_and_finish();
  end
  // Watchdog well beyond the expected run length.
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
